// File: verilog/fsb_pkg.sv
`default_nettype none
package fsb_pkg;
	localparam int NUM_PINS = 4;
	localparam int NUM_PORTS = 2;
	localparam logic [7:0] OFS_PIN_STATUS = 8'h0E;
	localparam logic [7:0] OFS_INPUT_CTL = 8'h0F;
	localparam logic [7:0] OFS_PIN_FUNC0 = 8'h10;
	localparam logic [7:0] OFS_SYNC_CTL = 8'h18;
	localparam logic [7:0] OFS_HIGH_UPPER = 8'h19;
	localparam logic [7:0] OFS_HIGH_LOWER = 8'h1A;
	localparam logic [7:0] OFS_LOW_UPPER = 8'h1B;
	localparam logic [7:0] OFS_LOW_LOWER = 8'h1C;
	localparam logic [7:0] OFS_PORT_SELECT = 8'h4C;
	localparam logic [7:0] OFS_RATE_SELECT = 8'h58;
	localparam logic [7:0] OFS_ROUTE_A = 8'h6E;
	localparam logic [7:0] OFS_ROUTE_B = 8'h6F;
	localparam logic [7:0] OFS_PULLDOWN_CTL = 8'hBE;
	localparam logic [7:0] RST_INPUT_CTL = 8'h00;
	localparam logic [7:0] RST_PULLDOWN_CTL = 8'h00;
	localparam logic [7:0] RST_PIN_FUNC = 8'h00;
	localparam logic [7:0] RST_SYNC_CTL = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [7:0] RST_PORT_SELECT = 8'h01;
	localparam logic [7:0] RST_RATE = 8'h00;
	localparam logic [7:0] RST_ROUTE = 8'h88;
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_DUTY_BIT = 1;
	localparam int CTL_START_BIT = 2;
	localparam int CTL_SRC_LSB = 4;
	localparam int PIN_OE_BIT = 0;
	localparam int PIN_DATA_BIT = 1;
	localparam int PIN_SYNC_OUT_BIT = 2;
	localparam int PSEL_READ_BIT = 4;
	localparam logic [3:0] SRC_PORT0_TICK = 4'h0;
	localparam logic [3:0] SRC_PORT1_TICK = 4'h1;
	localparam logic [3:0] SRC_EXT_PIN0 = 4'h8;
	localparam logic [3:0] SRC_EXT_PIN3 = 4'hB;
	localparam logic [3:0] ROUTE_PIN0 = 4'h0;
	localparam logic [3:0] ROUTE_PIN3 = 4'h3;
	localparam logic [3:0] ROUTE_LOW = 4'h8;
	localparam logic [3:0] ROUTE_HIGH = 4'h9;
	localparam logic [3:0] ROUTE_SYNC = 4'hA;
	localparam logic [2:0] RATE_2M5 = 3'h0;
	localparam int CLOCK_PERIOD_PS = 4000;
	localparam int BIT_TIME_NS = 400;
	localparam int BITS_PER_FRAME = 30;
	localparam int TICK_CYCLES = BITS_PER_FRAME * BIT_TIME_NS * 1000 / CLOCK_PERIOD_PS;
	localparam logic [11:0] TICK_LAST = 12'(TICK_CYCLES - 1);
endpackage
`default_nettype wire

// File: verilog/fsb_sync_gen.sv
`timescale 1ns/10ps
`default_nettype none
module fsb_sync_gen (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic tick,
	input wire logic enable,
	input wire logic duty_mode,
	input wire logic start_level,
	input wire logic [15:0] high_count,
	input wire logic [15:0] low_count,
	output logic level_r
);
	import fsb_pkg::*;

	logic [15:0] cnt_r;
	logic [15:0] len_r;
	logic run_r;

	// length of the phase at level lvl, never below one tick
	function automatic logic [15:0] phase_len(input logic lvl, input logic mode,
		input logic [15:0] hi, input logic [15:0] lo);
		logic [15:0] n;
		n = (lvl || mode) ? hi : lo;
		phase_len = (n == 16'h0000) ? 16'h0001 : n;
	endfunction

	// first enabled cycle loads the start level written with the enable
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			run_r <= 1'b0;
		end else begin
			run_r <= enable;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			level_r <= 1'b0;
			cnt_r <= 16'h0000;
			len_r <= 16'h0001;
		end else if (!enable || !run_r) begin
			level_r <= start_level;
			cnt_r <= 16'h0000;
			len_r <= phase_len(start_level, duty_mode, high_count, low_count);
		end else if (tick) begin
			if (cnt_r + 16'h0001 >= len_r) begin
				level_r <= ~level_r;
				cnt_r <= 16'h0000;
				len_r <= phase_len(~level_r, duty_mode, high_count, low_count);
			end else begin
				cnt_r <= cnt_r + 16'h0001;
			end
		end
	end
endmodule
`default_nettype wire

// File: verilog/fsb_top.sv
`timescale 1ns/10ps
`default_nettype none
module fsb_top (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_en,
	output logic [7:0] reg_rd_data,
	output logic reg_rd_valid,
	input wire logic [fsb_pkg::NUM_PINS-1:0] gpio_in,
	output logic [fsb_pkg::NUM_PINS-1:0] gpio_out,
	output logic [fsb_pkg::NUM_PINS-1:0] gpio_oe,
	output logic [fsb_pkg::NUM_PINS-1:0] gpio_input_disable,
	output logic [fsb_pkg::NUM_PINS-1:0] gpio_pulldown_disable,
	output logic [3:0] backchannel_gpio_signal_p0,
	output logic [3:0] backchannel_gpio_signal_p1,
	output logic frame_sync_pulse
);
	import fsb_pkg::*;

	// pin input synchronisers
	logic [NUM_PINS-1:0] pin_meta_r;
	logic [NUM_PINS-1:0] pin_sync_r;
	logic [NUM_PINS-1:0] pin_level;

	// register file
	logic [7:0] input_ctl_r;
	logic [7:0] pulldown_ctl_r;
	logic [7:0] pin_func_r [NUM_PINS];
	logic [7:0] sync_ctl_r;
	logic [15:0] high_count_r;
	logic [15:0] low_count_r;
	logic [7:0] port_select_r;
	logic [7:0] rate_r [NUM_PORTS];
	logic [15:0] route_r [NUM_PORTS];

	// generator side
	logic [NUM_PORTS-1:0] tick_r;
	logic gen_tick;
	logic gen_level;
	logic gen_enable;
	logic [3:0] sync_src;
	logic sync_nxt;

	logic [7:0] rd_nxt;
	logic read_port;

	// route selector to a back-channel level
	function automatic logic route_level(input logic [3:0] sel,
		input logic [NUM_PINS-1:0] pins, input logic fs);
		logic v;
		v = 1'b0;
		if (sel <= ROUTE_PIN3) begin
			v = pins[sel[1:0]];
		end else if (sel == ROUTE_HIGH) begin
			v = 1'b1;
		end else if (sel == ROUTE_SYNC) begin
			v = fs;
		end
		route_level = v;
	endfunction

	// true when addr hits the pin function block
	function automatic logic is_pin_func(input logic [7:0] addr);
		is_pin_func = (addr >= OFS_PIN_FUNC0) &&
			(addr < OFS_PIN_FUNC0 + 8'(NUM_PINS));
	endfunction

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pin_meta_r <= '0;
			pin_sync_r <= '0;
		end else begin
			pin_meta_r <= gpio_in;
			pin_sync_r <= pin_meta_r;
		end
	end

	// disabled input paths read as low
	assign pin_level = pin_sync_r & ~input_ctl_r[NUM_PINS-1:0];

	// upper four bits reserved, read as zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			input_ctl_r <= RST_INPUT_CTL;
		end else if (reg_wr_en && reg_addr == OFS_INPUT_CTL) begin
			input_ctl_r <= {4'h0, reg_wr_data[3:0]};
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			pulldown_ctl_r <= RST_PULLDOWN_CTL;
		end else if (reg_wr_en && reg_addr == OFS_PULLDOWN_CTL) begin
			pulldown_ctl_r <= {4'h0, reg_wr_data[3:0]};
		end
	end

	genvar gp;
	generate
		for (gp = 0; gp < NUM_PINS; gp++) begin : g_pin
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					pin_func_r[gp] <= RST_PIN_FUNC;
				end else if (reg_wr_en && reg_addr == OFS_PIN_FUNC0 + 8'(gp)) begin
					pin_func_r[gp] <= {5'h00, reg_wr_data[2:0]};
				end
			end

			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					gpio_oe[gp] <= 1'b0;
				end else begin
					gpio_oe[gp] <= pin_func_r[gp][PIN_OE_BIT];
				end
			end

			// pin may mirror the frame sync instead of a fixed level
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					gpio_out[gp] <= 1'b0;
				end else begin
					gpio_out[gp] <= pin_func_r[gp][PIN_SYNC_OUT_BIT] ?
						frame_sync_pulse : pin_func_r[gp][PIN_DATA_BIT];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gpio_input_disable <= '0;
		end else begin
			gpio_input_disable <= input_ctl_r[NUM_PINS-1:0];
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			gpio_pulldown_disable <= '0;
		end else begin
			gpio_pulldown_disable <= pulldown_ctl_r[NUM_PINS-1:0];
		end
	end

	// bit 3 reserved, reads as zero
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			sync_ctl_r <= RST_SYNC_CTL;
		end else if (reg_wr_en && reg_addr == OFS_SYNC_CTL) begin
			sync_ctl_r <= {reg_wr_data[7:4], 1'b0, reg_wr_data[2:0]};
		end
	end

	// bytes land at once; generator takes them at its next phase end
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			high_count_r <= RST_COUNT;
		end else if (reg_wr_en) begin
			case (reg_addr)
				OFS_HIGH_UPPER: high_count_r[15:8] <= reg_wr_data;
				OFS_HIGH_LOWER: high_count_r[7:0] <= reg_wr_data;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			low_count_r <= RST_COUNT;
		end else if (reg_wr_en) begin
			case (reg_addr)
				OFS_LOW_UPPER: low_count_r[15:8] <= reg_wr_data;
				OFS_LOW_LOWER: low_count_r[7:0] <= reg_wr_data;
				default: begin
				end
			endcase
		end
	end

	// write mask for per-port registers in bits 1:0, read port in bit 4
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			port_select_r <= RST_PORT_SELECT;
		end else if (reg_wr_en && reg_addr == OFS_PORT_SELECT) begin
			port_select_r <= {3'h0, reg_wr_data[PSEL_READ_BIT], 2'h0, reg_wr_data[1:0]};
		end
	end

	assign read_port = port_select_r[PSEL_READ_BIT];

	genvar pt;
	generate
		for (pt = 0; pt < NUM_PORTS; pt++) begin : g_port
			logic [11:0] tick_cnt_r;
			logic [3:0] bc_nxt;

			// per-port registers take writes only where the mask bit is set
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					rate_r[pt] <= RST_RATE;
				end else if (reg_wr_en && port_select_r[pt] && reg_addr == OFS_RATE_SELECT) begin
					rate_r[pt] <= reg_wr_data;
				end
			end

			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					route_r[pt] <= {RST_ROUTE, RST_ROUTE};
				end else if (reg_wr_en && port_select_r[pt]) begin
					if (reg_addr == OFS_ROUTE_A) begin
						route_r[pt][7:0] <= reg_wr_data;
					end
					if (reg_addr == OFS_ROUTE_B) begin
						route_r[pt][15:8] <= reg_wr_data;
					end
				end
			end

			// frame period tick; other rate codes keep the 2.5 Mbps frame
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					tick_cnt_r <= 12'h000;
				end else if (tick_cnt_r == TICK_LAST) begin
					tick_cnt_r <= 12'h000;
				end else begin
					tick_cnt_r <= tick_cnt_r + 12'h001;
				end
			end

			// one-cycle strobe at the end of each frame period
			always_ff @(posedge clock or negedge reset_n) begin
				if (!reset_n) begin
					tick_r[pt] <= 1'b0;
				end else begin
					tick_r[pt] <= (tick_cnt_r == TICK_LAST);
				end
			end

			always_comb begin
				bc_nxt = '0;
				for (int s = 0; s < 4; s++) begin
					bc_nxt[s] = route_level(route_r[pt][4*s +: 4], pin_level, frame_sync_pulse);
				end
			end

			if (pt == 0) begin : g_out0
				always_ff @(posedge clock or negedge reset_n) begin
					if (!reset_n) begin
						backchannel_gpio_signal_p0 <= 4'h0;
					end else begin
						backchannel_gpio_signal_p0 <= bc_nxt;
					end
				end
			end else begin : g_out1
				always_ff @(posedge clock or negedge reset_n) begin
					if (!reset_n) begin
						backchannel_gpio_signal_p1 <= 4'h0;
					end else begin
						backchannel_gpio_signal_p1 <= bc_nxt;
					end
				end
			end
		end
	endgenerate

	assign sync_src = sync_ctl_r[CTL_SRC_LSB +: 4];
	assign gen_tick = (sync_src == SRC_PORT1_TICK) ? tick_r[1] : tick_r[0];
	assign gen_enable = sync_ctl_r[CTL_ENABLE_BIT];

	fsb_sync_gen u_gen (
		.clock(clock),
		.reset_n(reset_n),
		.tick(gen_tick),
		.enable(gen_enable),
		.duty_mode(sync_ctl_r[CTL_DUTY_BIT]),
		.start_level(sync_ctl_r[CTL_START_BIT]),
		.high_count(high_count_r),
		.low_count(low_count_r),
		.level_r(gen_level)
	);

	// external pin source wins; otherwise generator when enabled, else low
	always_comb begin
		sync_nxt = 1'b0;
		if (sync_src >= SRC_EXT_PIN0 && sync_src <= SRC_EXT_PIN3) begin
			sync_nxt = pin_level[sync_src[1:0]];
		end else if (gen_enable) begin
			sync_nxt = gen_level;
		end
	end

	// one level feeds both the pins and the back channel
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			frame_sync_pulse <= 1'b0;
		end else begin
			frame_sync_pulse <= sync_nxt;
		end
	end

	always_comb begin
		rd_nxt = 8'h00;
		if (is_pin_func(reg_addr)) begin
			rd_nxt = pin_func_r[reg_addr[1:0]];
		end else begin
			case (reg_addr)
				OFS_PIN_STATUS: rd_nxt = {4'h0, pin_level};
				OFS_INPUT_CTL: rd_nxt = input_ctl_r;
				OFS_PULLDOWN_CTL: rd_nxt = pulldown_ctl_r;
				OFS_SYNC_CTL: rd_nxt = sync_ctl_r;
				OFS_HIGH_UPPER: rd_nxt = high_count_r[15:8];
				OFS_HIGH_LOWER: rd_nxt = high_count_r[7:0];
				OFS_LOW_UPPER: rd_nxt = low_count_r[15:8];
				OFS_LOW_LOWER: rd_nxt = low_count_r[7:0];
				OFS_PORT_SELECT: rd_nxt = port_select_r;
				OFS_RATE_SELECT: rd_nxt = rate_r[read_port];
				OFS_ROUTE_A: rd_nxt = route_r[read_port][7:0];
				OFS_ROUTE_B: rd_nxt = route_r[read_port][15:8];
				default: rd_nxt = 8'h00;
			endcase
		end
	end

	// read answer one cycle after the strobe
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
		end
	end

	// read data holds until the next read
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_rd_data <= 8'h00;
		end else if (reg_rd_en) begin
			reg_rd_data <= rd_nxt;
		end
	end
endmodule
`default_nettype wire

// File: sim/fsb_properties.sv
`timescale 1ns/10ps
`default_nettype none
module fsb_properties (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_rd_data,
	input wire logic reg_rd_valid,
	input wire logic [fsb_pkg::NUM_PINS-1:0] gpio_in,
	input wire logic [fsb_pkg::NUM_PINS-1:0] gpio_out,
	input wire logic [fsb_pkg::NUM_PINS-1:0] gpio_oe,
	input wire logic [fsb_pkg::NUM_PINS-1:0] gpio_input_disable,
	input wire logic [fsb_pkg::NUM_PINS-1:0] gpio_pulldown_disable,
	input wire logic [3:0] backchannel_gpio_signal_p0,
	input wire logic [3:0] backchannel_gpio_signal_p1,
	input wire logic frame_sync_pulse
);
	import fsb_pkg::*;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!reset_n);
	logic [7:0] last_wr_r;
	// last written byte, compared against the pin copies
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) last_wr_r <= 8'h00;
		else if (reg_wr_en) last_wr_r <= reg_wr_data;
	end
	rd_answer_a: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read not answered");
	rd_once_a: assert property (reg_rd_valid |-> $past(reg_rd_en))
		else $error("read valid without read");
	rd_hold_a: assert property (!reg_rd_valid |-> $stable(reg_rd_data))
		else $error("read data moved");
	status_top_a: assert property (reg_rd_en && reg_addr == OFS_PIN_STATUS |=>
		reg_rd_data[7:4] == 4'h0) else $error("status upper bits set");
	unmapped_a: assert property (reg_rd_en && reg_addr == 8'h30 |=> reg_rd_data == 8'h00)
		else $error("unmapped read not zero");
	in_dis_a: assert property (reg_wr_en && reg_addr == OFS_INPUT_CTL |->
		##[1:2] gpio_input_disable == last_wr_r[3:0]) else $error("input disable wrong");
	pd_dis_a: assert property (reg_wr_en && reg_addr == OFS_PULLDOWN_CTL |->
		##[1:2] gpio_pulldown_disable == last_wr_r[3:0]) else $error("pulldown wrong");
	pin_drive_a: assert property (reg_wr_en && reg_addr == OFS_PIN_FUNC0 &&
		reg_wr_data[2:0] == 3'h3 |-> ##[1:2] gpio_oe[0] && gpio_out[0])
		else $error("pin not driven");
	sync_off_a: assert property (reg_wr_en && reg_addr == OFS_SYNC_CTL &&
		reg_wr_data == 8'h00 |-> ##[1:3] !frame_sync_pulse) else $error("sync not off");
	cover property ($rose(frame_sync_pulse));
	cover property ($fell(frame_sync_pulse));
	cover property (reg_rd_valid);
endmodule
bind fsb_top fsb_properties chk_u (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
	.reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
	.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .gpio_in(gpio_in),
	.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_input_disable(gpio_input_disable),
	.gpio_pulldown_disable(gpio_pulldown_disable),
	.backchannel_gpio_signal_p0(backchannel_gpio_signal_p0),
	.backchannel_gpio_signal_p1(backchannel_gpio_signal_p1),
	.frame_sync_pulse(frame_sync_pulse));
`default_nettype wire

// File: sim/fsb_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module fsb_far_model (
	input wire logic clock,
	input wire logic [3:0] bc_level,
	output logic [15:0] high_len,
	output logic [15:0] low_len
);
	logic prev_r;
	logic [15:0] cnt_r;
	// phase widths as the serializer sees them on signal 0
	always_ff @(posedge clock) begin
		prev_r <= bc_level[0];
		if (bc_level[0] !== prev_r) begin
			if (prev_r) high_len <= cnt_r;
			else low_len <= cnt_r;
			cnt_r <= 16'h0001;
		end else begin
			cnt_r <= cnt_r + 16'h0001;
		end
	end
endmodule
`default_nettype wire

// File: sim/frame_sync_and_backchannel_gpio_tb.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin failures++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module frame_sync_and_backchannel_gpio_tb;
	import fsb_pkg::*;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data;
	logic reg_wr_en = 1'b0, reg_rd_en = 1'b0, reg_rd_valid, frame_sync_pulse;
	logic [3:0] gpio_out, gpio_oe, in_dis, pd_dis, bc0, bc1;
	logic [3:0] pin_drv = 4'hB;
	wire logic [3:0] gpio_in = (gpio_oe & gpio_out) | (~gpio_oe & pin_drv);
	logic [15:0] high_len, low_len;
	logic [7:0] ra [12] = '{8'h0F, 8'hBE, 8'h10, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C,
		8'h58, 8'h6E, 8'h6F, 8'h4C};
	int failures = 0, total_checks = 0, cyc = 0;
	always #2 clock = ~clock;
	fsb_top dut_u (.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr),
		.reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
		.reg_rd_data(reg_rd_data), .reg_rd_valid(reg_rd_valid), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_input_disable(in_dis),
		.gpio_pulldown_disable(pd_dis), .backchannel_gpio_signal_p0(bc0),
		.backchannel_gpio_signal_p1(bc1), .frame_sync_pulse(frame_sync_pulse));
	fsb_far_model far_u (.clock(clock), .bc_level(bc0), .high_len(high_len),
		.low_len(low_len));
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		reg_addr = a;
		reg_wr_data = d;
		reg_wr_en = 1'b1;
		@(negedge clock);
		reg_wr_en = 1'b0;
		@(negedge clock);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge clock);
		reg_addr = a;
		reg_rd_en = 1'b1;
		@(negedge clock);
		reg_rd_en = 1'b0;
		`CHK("rd_valid", 1'b1, reg_rd_valid)
		`CHK("rd_data", e, reg_rd_data)
	endtask
	// bounded by the cycle ceiling below
	task automatic wait_fs(input logic lvl);
		while (frame_sync_pulse !== lvl) @(negedge clock);
		repeat (3) @(negedge clock);
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 50000) begin
			failures++;
			close_out();
		end
	end
	initial begin
		repeat (12) @(negedge clock);
		reset_n = 1'b1;
		for (int i = 0; i < 12; i++) begin
			rd(ra[i], i < 9 ? 8'h00 : (i < 11 ? RST_ROUTE : RST_PORT_SELECT));
		end
		wr(8'h0F, 8'h0F);
		`CHK("in_dis", 4'hF, in_dis)
		rd(8'h0E, 8'h00);
		wr(8'h0F, 8'h00);
		wr(8'hBE, 8'h0A);
		`CHK("pd_dis", 4'hA, pd_dis)
		wr(8'hBE, 8'h00);
		wr(8'h0E, 8'hFF);
		repeat (3) @(negedge clock);
		rd(8'h0E, 8'h0B);
		wr(8'h10, 8'h01);
		repeat (3) @(negedge clock);
		rd(8'h0E, 8'h0A);
		wr(8'h10, 8'h03);
		`CHK("pin_out", 2'b11, {gpio_oe[0], gpio_out[0]})
		wr(8'h10, 8'h00);
		wr(8'h30, 8'h55);
		rd(8'h30, 8'h00);
		wr(8'h58, 8'h07);
		rd(8'h58, 8'h07);
		wr(8'h4C, 8'h03);
		wr(8'h6F, 8'h98);
		for (int p = 0; p < 4; p++) begin
			wr(8'h6E, {p[3:0], p[3:0]});
			repeat (6) @(negedge clock);
			`CHK("bc_p0", {2{pin_drv[p]}}, bc0[1:0])
			`CHK("bc_p1", {2{pin_drv[p]}}, bc1[1:0])
		end
		`CHK("bc_const", 2'b10, bc0[3:2])
		wr(8'h6E, 8'hAA);
		for (int p = 0; p < 4; p++) begin
			wr(8'h18, {4'h8 + p[3:0], 4'h0});
			repeat (6) @(negedge clock);
			`CHK("ext_fs", pin_drv[p], frame_sync_pulse)
			`CHK("bc_fs", {2{pin_drv[p]}}, bc0[1:0])
		end
		wr(8'h18, 8'h05);
		repeat (2) @(negedge clock);
		`CHK("start_hi", 1'b1, frame_sync_pulse)
		wr(8'h18, 8'h00);
		`CHK("gen_off", 1'b0, frame_sync_pulse)
		wr(8'h19, 8'h00);
		wr(8'h1A, 8'h01);
		wr(8'h1B, 8'h00);
		wr(8'h1C, 8'h02);
		wr(8'h18, 8'h01);
		wait_fs(1'b1);
		repeat (1000) @(negedge clock);
		wr(8'h1A, 8'h02);
		wait_fs(1'b0);
		`CHK("high_1", 16'(TICK_CYCLES), high_len)
		wait_fs(1'b1);
		`CHK("low_2", 16'(2 * TICK_CYCLES), low_len)
		wait_fs(1'b0);
		`CHK("high_2", 16'(2 * TICK_CYCLES), high_len)
		wr(8'h10, 8'h05);
		wr(8'h18, 8'h00);
		wr(8'h1A, 8'h01);
		wr(8'h18, 8'h03);
		wait_fs(1'b1);
		`CHK("pin_fs_hi", 2'b11, {gpio_oe[0], gpio_out[0]})
		wait_fs(1'b0);
		`CHK("half_hi", 16'(TICK_CYCLES), high_len)
		`CHK("pin_fs_lo", 2'b10, {gpio_oe[0], gpio_out[0]})
		wait_fs(1'b1);
		`CHK("half_lo", 16'(TICK_CYCLES), low_len)
		close_out();
	end
endmodule
`default_nettype wire
